// ### src/sfa_core.sv
// Purpose: Arithmetic flag register, pointer pairs and data address formation.
// Assumes: Decoder presents one address request and one ALU operation per cycle at most.
// Notes: Results and data addresses appear one cycle after their request, from flip-flops.
`include "sfa_map.svh"

module sfa_core
  import sfa_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic addrReq,
  input wire logic [7:0] addrFile,
  input wire logic addrAccess,
  input wire logic addrFullValid,
  input wire logic [11:0] addrFull,
  input wire logic [3:0] bankSelect,
  input wire logic [7:0] workReg,
  output logic [11:0] memAddr,
  output logic memAddrValid,
  output logic memIndirect,
  input wire logic aluValid,
  input wire sfa_op_t aluOp,
  input wire logic [7:0] aluFileData,
  input wire logic [7:0] aluWorkData,
  input wire logic [2:0] aluBit,
  input wire logic [11:0] aluAddr,
  input wire logic aluHasDest,
  input wire logic aluDest,
  input wire logic aluImplicitFile,
  input wire logic [19:0] callTarget,
  output logic [19:0] callAddr,
  output logic [4:0] flags,
  output logic [11:0] wbAddr,
  output logic [7:0] wbData,
  output logic wbFile,
  output logic wbWork
);

  sfa_state_t stQ;
  sfa_state_t stD;

  // Returns the pointer byte number (0 to 5) for a data-space location that holds a pointer byte, else 7.
  function automatic logic [2:0] ptrByteAt(input logic [11:0] a);
    logic [11:0] off;
    off = a - `SFA_DADDR_PTR_BASE;
    ptrByteAt = 3'h7;
    if (a >= `SFA_DADDR_PTR_BASE && off < 12'h006) begin
      ptrByteAt = off[2:0];
    end
  endfunction

  // Tells whether a data-space location is one of the virtual operands.
  // The span runs to the top of the 12-bit space, so base plus span would wrap to zero;
  // comparing the offset from the base avoids that.
  function automatic logic isVirtual(input logic [11:0] a);
    logic [11:0] off;
    off = a - `SFA_DADDR_VIRT_BASE;
    isVirtual = (a >= `SFA_DADDR_VIRT_BASE) && (off < `SFA_VIRT_SPAN);
  endfunction

  // Reads one byte of a pointer; the unused high nibble always reads zero.
  function automatic logic [7:0] ptrByte(input logic [11:0] p, input logic hi);
    ptrByte = hi ? {4'h0, p[11:8]} : p[7:0];
  endfunction

  // Next state of the whole block.
  always_comb begin
    logic [11:0] ea;
    logic [11:0] vOff;
    logic [1:0] vIdx;
    logic [2:0] vKind;
    logic [2:0] pb;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] addend;
    logic [7:0] res;
    logic setArith;
    logic setLogic;
    logic toFile;
    logic toWork;
    logic flagDst;
    logic [4:0] fl;
    ea = `SFA_ADDR_RESET;
    vOff = `SFA_ADDR_RESET;
    vIdx = 2'h0;
    vKind = `SFA_VK_PLAIN;
    pb = 3'h7;
    sum = 9'h000;
    nib = 5'h00;
    addend = `SFA_BYTE_ZERO;
    res = `SFA_BYTE_ZERO;
    setArith = 1'b0;
    setLogic = 1'b0;
    toFile = 1'b0;
    toWork = 1'b0;
    flagDst = 1'b0;
    fl = stQ.flags;
    stD = stQ;
    stD.memAddrValid = 1'b0;
    stD.wbFile = 1'b0;
    stD.wbWork = 1'b0;
    stD.rdData = `SFA_BYTE_ZERO;

    // Register port writes; core updates below take precedence on a clash.
    if (regWrite) begin
      if (regAddr == `SFA_REG_FLAGS) begin
        stD.flags = regWrData[4:0];
      end else if (regAddr == `SFA_REG_CONFIG) begin
        stD.extended_set_config_bit = regWrData[`SFA_CONFIG_EXTENDED_SET_CONFIG_BIT];
      end else if (regAddr >= `SFA_REG_PTR_BASE && regAddr < `SFA_REG_CONFIG) begin
        pb = 3'(regAddr - `SFA_REG_PTR_BASE);
        if (pb[0]) begin
          stD.ptr[pb[2:1]][11:8] = regWrData[3:0];
        end else begin
          stD.ptr[pb[2:1]][7:0] = regWrData;
        end
      end
    end

    // Address formation for the next memory access.
    if (addrReq) begin
      if (addrFullValid) begin
        ea = addrFull;
      end else if (addrAccess) begin
        ea = {bankSelect, addrFile};
      end else if (stQ.extended_set_config_bit && addrFile <= `SFA_INDEX_LIMIT) begin
        ea = stQ.ptr[2] + {4'h0, addrFile};
      end else if (addrFile < `SFA_ACCESS_SPLIT) begin
        ea = {`SFA_ACCESS_LOW_BANK, addrFile};
      end else begin
        ea = {`SFA_ACCESS_HIGH_BANK, addrFile};
      end
      stD.memIndirect = 1'b0;
      // A virtual operand is replaced by its pointer's target; banking plays no part.
      if (isVirtual(ea)) begin
        vOff = ea - `SFA_DADDR_VIRT_BASE;
        vIdx = vOff[4:3];
        vKind = vOff[2:0];
        stD.memIndirect = 1'b1;
        unique case (vKind)
          `SFA_VK_PREINC: begin
            ea = stQ.ptr[vIdx] + `SFA_PTR_ONE;
            stD.ptr[vIdx] = ea;
          end
          `SFA_VK_PLUSW: begin
            ea = stQ.ptr[vIdx] + {{4{workReg[7]}}, workReg};
          end
          `SFA_VK_POST_INCREMENT_OPERAND: begin
            ea = stQ.ptr[vIdx];
            stD.ptr[vIdx] = stQ.ptr[vIdx] + `SFA_PTR_ONE;
          end
          `SFA_VK_POSTDEC: begin
            ea = stQ.ptr[vIdx];
            stD.ptr[vIdx] = stQ.ptr[vIdx] - `SFA_PTR_ONE;
          end
          default: begin
            ea = stQ.ptr[vIdx];
          end
        endcase
      end
      stD.memAddr = ea;
      stD.memAddrValid = 1'b1;
    end

    // ALU result and flag derivation.
    if (aluValid) begin
      addend = (aluOp == SFA_OP_SUB) ? ~aluWorkData : aluWorkData;
      unique case (aluOp)
        SFA_OP_ADD, SFA_OP_SUB: begin
          // Subtraction adds the complement plus one, so a borrow shows as carry clear.
          sum = {1'b0, aluFileData} + {1'b0, addend} +
                {8'h00, aluOp == SFA_OP_SUB};
          nib = {1'b0, aluFileData[3:0]} + {1'b0, addend[3:0]} +
                {4'h0, aluOp == SFA_OP_SUB};
          res = sum[7:0];
          setArith = 1'b1;
        end
        SFA_OP_AND: begin
          res = aluFileData & aluWorkData;
          setLogic = 1'b1;
        end
        SFA_OP_IOR: begin
          res = aluFileData | aluWorkData;
          setLogic = 1'b1;
        end
        SFA_OP_XOR: begin
          res = aluFileData ^ aluWorkData;
          setLogic = 1'b1;
        end
        SFA_OP_RLC: begin
          res = {aluFileData[6:0], stQ.flags[`SFA_FLAG_C]};
          fl[`SFA_FLAG_C] = aluFileData[7];
          fl[`SFA_FLAG_DC] = aluFileData[3];
          setLogic = 1'b1;
        end
        SFA_OP_RRC: begin
          res = {stQ.flags[`SFA_FLAG_C], aluFileData[7:1]};
          fl[`SFA_FLAG_C] = aluFileData[0];
          fl[`SFA_FLAG_DC] = aluFileData[4];
          setLogic = 1'b1;
        end
        SFA_OP_CLR: begin
          res = `SFA_BYTE_ZERO;
          fl[`SFA_FLAG_Z] = 1'b1;
        end
        // These never derive flags.
        SFA_OP_BSET: res = aluFileData | (8'h01 << aluBit);
        SFA_OP_BCLR: res = aluFileData & ~(8'h01 << aluBit);
        SFA_OP_SWAP: res = {aluFileData[3:0], aluFileData[7:4]};
        SFA_OP_FILE_TO_FILE_MOVE: res = aluFileData;
        SFA_OP_WORKING_TO_FILE_MOVE: res = aluWorkData;
        default: res = aluFileData;
      endcase
      if (setArith) begin
        fl[`SFA_FLAG_C] = sum[8];
        fl[`SFA_FLAG_DC] = nib[4];
        fl[`SFA_FLAG_OV] = (aluFileData[7] == addend[7]) &&
                           (res[7] != aluFileData[7]);
      end
      if (setArith || setLogic) begin
        fl[`SFA_FLAG_N] = res[7];
        fl[`SFA_FLAG_Z] = (res == `SFA_BYTE_ZERO);
      end
      // Destination choice: explicit bit first, else the implicit one.
      if (aluHasDest) begin
        toFile = aluDest;
      end else begin
        toFile = aluImplicitFile;
      end
      toWork = !toFile;
      flagDst = toFile && (aluAddr == `SFA_DADDR_FLAGS);
      pb = ptrByteAt(aluAddr);
      if (flagDst && (setArith || setLogic || aluOp == SFA_OP_CLR ||
                      aluOp == SFA_OP_RLC || aluOp == SFA_OP_RRC)) begin
        stD.flags = fl;
      end else if (flagDst) begin
        stD.flags = res[4:0];
      end else begin
        stD.flags = fl;
      end
      // File writes that land on pointer bytes update them here; memory never sees them.
      if (toFile && pb != 3'h7) begin
        if (pb[0]) begin
          stD.ptr[pb[2:1]][11:8] = res[3:0];
        end else begin
          stD.ptr[pb[2:1]][7:0] = res;
        end
      end
      stD.wbAddr = aluAddr;
      stD.wbData = res;
      stD.wbFile = toFile && !flagDst && (pb == 3'h7);
      stD.wbWork = toWork;
    end

    // Register port read data, valid in the following cycle only.
    if (regRead) begin
      if (regAddr == `SFA_REG_FLAGS) begin
        stD.rdData = {3'h0, stQ.flags};
      end else if (regAddr == `SFA_REG_CONFIG) begin
        stD.rdData = {7'h00, stQ.extended_set_config_bit};
      end else if (regAddr >= `SFA_REG_PTR_BASE && regAddr < `SFA_REG_CONFIG) begin
        pb = 3'(regAddr - `SFA_REG_PTR_BASE);
        stD.rdData = ptrByte(stQ.ptr[pb[2:1]], pb[0]);
      end else begin
        stD.rdData = `SFA_REG_NONE;
      end
    end
  end

  // State register; flags start at zero since the hardware leaves them undefined.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  // Call and jump targets pass through as the full program address.
  assign callAddr = callTarget;
  assign regRdData = stQ.rdData;
  assign memAddr = stQ.memAddr;
  assign memAddrValid = stQ.memAddrValid;
  assign memIndirect = stQ.memIndirect;
  assign flags = stQ.flags;
  assign wbAddr = stQ.wbAddr;
  assign wbData = stQ.wbData;
  assign wbFile = stQ.wbFile;
  assign wbWork = stQ.wbWork;

endmodule

// ### shared/sfa_map.svh
// Purpose: Named offsets, field positions and reset values of the flag and addressing block.
// Assumes: One core clock; 8-bit register port; 12-bit linear data space.
// Notes: Every number the logic needs is named here once.
// Summary of operation
// - Flag-changing instruction targeting flag register keeps logic flags, drops written flags.
// - Clearing the flag register sets only zero flag; reads 000u u1uu.
// - Bit set/clear, swap, file-to-file and working moves change flags only when their destination is the flag register.
// - Flag register bits 7-5 read zero; five flags power up unknown (reset here clears them to zero).
// - Negative flag, bit 4, takes the result's most significant bit.
// - Signed wrap flag, bit 3, set when sign wrongly changes by overflow.
// - Zero flag, bit 2, set when an arithmetic or logic result is zero.
// - Add/subtract: nibble carry flag, bit 1, is carry out of result bit 3.
// - Add/subtract: carry flag, bit 0, is carry out of result bit 7.
// - Subtraction adds the two's complement; carries act as inverted borrows.
// - Rotates load nibble carry from bit 4 or 3, carry from end bit.
// - Direct: access bit one joins bank select and address; zero uses access bank.
// - Full 12-bit address in the opcode ignores the bank select register.
// - Destination bit one writes back to file, zero to working register.
// - No destination bit: result goes to the instruction's implicit destination.
// - Three pointer pairs of high and low bytes hold 12-bit addresses.
// - Virtual indirect operand has no storage; accesses the pointer's location.
// - Indirect target ignores bank select and access bit completely.
// - Literal call and jump carry a 20-bit program address in the opcode.
// - Indexed literal-offset mode exists only with the extended set bit one.
// - Post-increment accesses then increments; post-decrement accesses then decrements; pre-increment increments, then accesses.
// - Pointer steps act on the whole pair with carry and change no flag.
`ifndef SFA_MAP_SVH
`define SFA_MAP_SVH
// Register port offsets.
`define SFA_REG_FLAGS 4'h0
`define SFA_REG_PTR_BASE 4'h1
`define SFA_REG_CONFIG 4'h7
`define SFA_REG_NONE 8'h00
// Flag bit positions and masks.
`define SFA_FLAG_C 0
`define SFA_FLAG_DC 1
`define SFA_FLAG_Z 2
`define SFA_FLAG_OV 3
`define SFA_FLAG_N 4
`define SFA_FLAG_MASK 8'h1F
`define SFA_FLAG_RESET 5'h00
`define SFA_CONFIG_EXTENDED_SET_CONFIG_BIT 0
// Data-space locations of the block's own registers.
`define SFA_DADDR_FLAGS 12'hFD0
`define SFA_DADDR_PTR_BASE 12'hFE0
`define SFA_DADDR_VIRT_BASE 12'hFE8
`define SFA_VIRT_SPAN 12'h018
`define SFA_VIRT_STRIDE_SHIFT 3
// Kinds of virtual operand inside one stride.
`define SFA_VK_PLAIN 3'h0
`define SFA_VK_POST_INCREMENT_OPERAND 3'h1
`define SFA_VK_POSTDEC 3'h2
`define SFA_VK_PREINC 3'h3
`define SFA_VK_PLUSW 3'h4
// Direct addressing limits.
`define SFA_ACCESS_SPLIT 8'h60
`define SFA_INDEX_LIMIT 8'h5F
`define SFA_ACCESS_HIGH_BANK 4'hF
`define SFA_ACCESS_LOW_BANK 4'h0
`define SFA_NIBBLE_MASK 4'hF
`define SFA_PTR_ONE 12'h001
`define SFA_PTR_RESET 12'h000
`define SFA_ADDR_RESET 12'h000
`define SFA_BYTE_ZERO 8'h00
`define SFA_CALL_BITS 20
`endif

// ### shared/sfa_pkg.sv
// Purpose: Types of the flag and addressing block.
// Assumes: Constants come from sfa_map.svh.
// Notes: The whole state of the block is one packed struct.
package sfa_pkg;
  // Operation kinds handed over by the decoder.
  typedef enum logic [3:0] {
    SFA_OP_ADD, SFA_OP_SUB, SFA_OP_AND, SFA_OP_IOR, SFA_OP_XOR,
    SFA_OP_RLC, SFA_OP_RRC, SFA_OP_CLR, SFA_OP_BSET, SFA_OP_BCLR,
    SFA_OP_SWAP, SFA_OP_FILE_TO_FILE_MOVE, SFA_OP_WORKING_TO_FILE_MOVE
  } sfa_op_t;

  typedef struct packed {
    logic [4:0] flags;
    logic [2:0][11:0] ptr;
    logic extended_set_config_bit;
    logic [7:0] rdData;
    logic [11:0] memAddr;
    logic memAddrValid;
    logic memIndirect;
    logic [11:0] wbAddr;
    logic [7:0] wbData;
    logic wbFile;
    logic wbWork;
  } sfa_state_t;
endpackage

// ### verif/sfa_core_props.sv
// Purpose: Port-level checks of flag results and address forming.
// Assumes: One clock domain, rst_n asynchronous and active low.
// Notes: Carries are recomputed here from the operands, never taken from the block.
module sfa_core_props import sfa_pkg::*; (
  input logic clk,
  input logic rst_n,
  input logic [3:0] regAddr,
  input logic regRead,
  input logic regWrite,
  input logic [7:0] regRdData,
  input logic addrReq,
  input logic [7:0] addrFile,
  input logic addrAccess,
  input logic addrFullValid,
  input logic [3:0] bankSelect,
  input logic [11:0] memAddr,
  input logic memIndirect,
  input logic aluValid,
  input sfa_op_t aluOp,
  input logic [7:0] aluFileData,
  input logic [7:0] aluWorkData,
  input logic [11:0] aluAddr,
  input logic aluHasDest,
  input logic aluDest,
  input logic [7:0] wbData,
  input logic [11:0] wbAddr,
  input logic wbFile,
  input logic [4:0] flags
);
  // Nine bits keep the carry out of bit 7; the concatenation stops the inversion spreading.
  logic [8:0] addSum, subSum;
  logic [4:0] addNib;
  assign addSum = aluFileData + aluWorkData;
  assign subSum = aluFileData + {1'b0, ~aluWorkData} + 9'h001;
  assign addNib = aluFileData[3:0] + aluWorkData[3:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Results land one cycle after the request.
  a_flag_read: assert property (
    regRead && regAddr == 4'h0 |=> regRdData == {3'h0, $past(flags)}) else $error("flag read");
  a_bank_join: assert property (
    addrReq && addrAccess && !addrFullValid && bankSelect != 4'hF |=>
    memAddr == {$past(bankSelect), $past(addrFile)} && !memIndirect) else $error("bank join");
  a_access_top: assert property (
    addrReq && !addrAccess && !addrFullValid && addrFile inside {[8'h60:8'hE7]} |=>
    memAddr == {4'hF, $past(addrFile)}) else $error("access bank upper half");
  a_dest_file: assert property (
    aluValid && aluHasDest && aluDest && aluAddr < 12'hF00 |=>
    wbFile && wbAddr == $past(aluAddr)) else $error("file writeback");
  a_zero_neg: assert property (
    aluValid && aluOp <= SFA_OP_XOR |=>
    flags[2] == (wbData == 8'h00) && flags[4] == wbData[7]) else $error("zero or negative");
  a_add_carry: assert property (
    aluValid && aluOp == SFA_OP_ADD |=>
    flags[1:0] == {$past(addNib[4]), $past(addSum[8])}) else $error("add carries");
  a_sub_borrow: assert property (
    aluValid && aluOp == SFA_OP_SUB |=> flags[0] == $past(subSum[8])) else $error("borrow");
  a_flags_keep: assert property (
    aluValid && aluOp >= SFA_OP_BSET && aluAddr != 12'hFD0 && !regWrite |=> $stable(flags))
    else $error("flags moved");
endmodule

bind sfa_core sfa_core_props u_props (.*);

// ### verif/sfa_data_mem.sv
// Purpose: Behavioural banked data memory beyond the block.
// Assumes: Filled by file writebacks, read at the last formed address.
// Notes: Unwritten bytes read unknown, as real memory does after power-up.
module sfa_data_mem (
  input logic clk,
  input logic [11:0] memAddr,
  input logic [11:0] wbAddr,
  input logic [7:0] wbData,
  input logic wbFile,
  output logic [7:0] rdData
);
  logic [7:0] mem [4096];
  // A writeback is stored at the edge that sees its pulse.
  always @(posedge clk) if (wbFile) mem[wbAddr] <= wbData;
  assign rdData = mem[memAddr];
endmodule

// ### verif/testbench.sv
// Purpose: Self-checking bench of the flag register and address forming.
// Assumes: The tasks play decoder, ALU and register master.
// Notes: Outputs are sampled at the falling edge, after the launching edge settled.
module testbench import sfa_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, regWrite, regRead, addrReq, addrAccess, addrFullValid, memAddrValid;
  logic memIndirect, aluValid, aluHasDest, aluDest, aluImplicitFile, wbFile, wbWork;
  logic [2:0] aluBit;
  logic [3:0] regAddr, bankSelect;
  logic [4:0] flags;
  logic [7:0] regWrData, regRdData, addrFile, workReg, aluFileData, aluWorkData, wbData, rdData;
  logic [11:0] addrFull, memAddr, aluAddr, wbAddr;
  logic [19:0] callTarget, callAddr;
  sfa_op_t aluOp;
  int nMismatch, comparisons;

  sfa_core uut (.*);
  sfa_data_mem memModel (.*);

  // Core clock, 20 ns period.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bus cycles; each strobe stands for exactly one cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdData, e);
  endtask

  // An unknown expectation for the pointer marker means it is not judged.
  task automatic ad(input logic acc, input logic [7:0] f, input logic fv,
                    input logic [3:0] bk, input logic [11:0] e, input logic ind);
    @(posedge clk);
    {addrReq, addrAccess, addrFile, addrFullValid, bankSelect} <= {1'b1, acc, f, fv, bk};
    @(posedge clk);
    addrReq <= 1'b0;
    @(negedge clk);
    chk(memAddrValid, 1'b1);
    chk(memAddr, e);
    if (ind !== 1'bx) chk(memIndirect, ind);
  endtask

  task automatic op(input sfa_op_t o, input logic [7:0] f, w, input logic [11:0] a,
                    input logic [1:0] dc, input logic [7:0] eD, input logic [4:0] eF,
                    input logic [1:0] eWb);
    @(posedge clk);
    {aluValid, aluFileData, aluWorkData, aluAddr, aluHasDest, aluDest} <= {1'b1, f, w, a, dc};
    aluOp <= o;
    @(posedge clk);
    aluValid <= 1'b0;
    @(negedge clk);
    chk(flags, eF);
    chk({wbFile, wbWork}, eWb);
    if (eWb[1]) chk(wbAddr, a);
    if (eWb != 2'h0) chk(wbData, eD);
  endtask

  task automatic t_pointers();
    rd(4'h0, 8'h00);
    wr(4'h1, 8'hFF);
    wr(4'h2, 8'hA1);
    rd(4'h2, 8'h01);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00);
    ad(1'b0, 8'hE9, 1'b0, 4'h0, 12'h1FF, 1'b1);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h02);
    ad(1'b0, 8'hEB, 1'b0, 4'h0, 12'h201, 1'b1);
    ad(1'b0, 8'hEA, 1'b0, 4'h0, 12'h201, 1'b1);
    ad(1'b1, 8'hE8, 1'b0, 4'hF, 12'h200, 1'b1);
    chk(flags, 5'h00);
    // Signed working offset of minus two; the pointer itself must not move.
    @(posedge clk);
    workReg <= 8'hFE;
    ad(1'b0, 8'hEC, 1'b0, 4'h0, 12'h1FE, 1'b1);
    rd(4'h1, 8'h00);
  endtask

  task automatic t_direct();
    ad(1'b1, 8'h45, 1'b0, 4'h3, 12'h345, 1'b0);
    ad(1'b0, 8'h70, 1'b0, 4'h3, 12'hF70, 1'b0);
    ad(1'b0, 8'h20, 1'b0, 4'h3, 12'h020, 1'b0);
    ad(1'b1, 8'h45, 1'b1, 4'h7, 12'h123, 1'b0);
  endtask

  // Logic, rotate, clear and flag-keeping rows lean on the flags left by the row above them.
  task automatic t_alu();
    op(SFA_OP_ADD, 8'h7F, 8'h01, 12'h010, 2'h2, 8'h80, 5'h1A, 2'h1);
    op(SFA_OP_ADD, 8'hFF, 8'h01, 12'h010, 2'h3, 8'h00, 5'h07, 2'h2);
    op(SFA_OP_SUB, 8'h05, 8'h05, 12'h010, 2'h2, 8'h00, 5'h07, 2'h1);
    op(SFA_OP_SUB, 8'h00, 8'h01, 12'h010, 2'h2, 8'hFF, 5'h10, 2'h1);
    op(SFA_OP_SUB, 8'h80, 8'h01, 12'h010, 2'h2, 8'h7F, 5'h09, 2'h1);
    op(SFA_OP_AND, 8'hF0, 8'h0F, 12'h010, 2'h2, 8'h00, 5'h0D, 2'h1);
    op(SFA_OP_IOR, 8'h80, 8'h01, 12'h010, 2'h2, 8'h81, 5'h19, 2'h1);
    op(SFA_OP_XOR, 8'hFF, 8'hFF, 12'h010, 2'h2, 8'h00, 5'h0D, 2'h1);
    op(SFA_OP_RLC, 8'h88, 8'h00, 12'h010, 2'h2, 8'h11, 5'h0B, 2'h1);
    op(SFA_OP_RRC, 8'h11, 8'h00, 12'h010, 2'h2, 8'h88, 5'h1B, 2'h1);
    op(SFA_OP_CLR, 8'h1B, 8'h00, 12'hFD0, 2'h0, 8'h00, 5'h1F, 2'h0);
    rd(4'h0, 8'h1F);
    op(SFA_OP_ADD, 8'h01, 8'h01, 12'hFD0, 2'h3, 8'h02, 5'h00, 2'h0);
    op(SFA_OP_BSET, 8'h00, 8'h00, 12'hFD0, 2'h0, 8'h01, 5'h01, 2'h0);
    op(SFA_OP_WORKING_TO_FILE_MOVE, 8'h00, 8'h5A, 12'h010, 2'h0, 8'h5A, 5'h01, 2'h2);
    op(SFA_OP_SWAP, 8'h12, 8'h00, 12'h010, 2'h2, 8'h21, 5'h01, 2'h1);
    op(SFA_OP_FILE_TO_FILE_MOVE, 8'h33, 8'h00, 12'h020, 2'h0, 8'h33, 5'h01, 2'h2);
    op(SFA_OP_BCLR, 8'h01, 8'h00, 12'hFD0, 2'h0, 8'h00, 5'h00, 2'h0);
  endtask

  task automatic t_extended();
    wr(4'h7, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h02);
    ad(1'b0, 8'h10, 1'b0, 4'h0, 12'h210, 1'bx);
    ad(1'b0, 8'h70, 1'b0, 4'h0, 12'hF70, 1'b0);
    wr(4'h7, 8'h00);
    ad(1'b0, 8'h10, 1'b0, 4'h0, 12'h010, 1'b0);
    chk(rdData, 8'h5A);
  endtask

  // Main sequence; reset is held for 20 cycles.
  initial begin
    {rst_n, regWrite, regRead, addrReq, addrAccess, addrFullValid, aluValid, aluHasDest} = '0;
    {aluDest, regAddr, regWrData, addrFile, bankSelect, aluFileData, aluWorkData, aluAddr} = '0;
    aluOp = SFA_OP_ADD;
    aluBit = 3'h0;
    aluImplicitFile = 1'b1;
    workReg = 8'h00;
    addrFull = 12'h123;
    callTarget = 20'hABCDE;
    nMismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk(callAddr, 20'hABCDE);
    t_pointers();
    t_direct();
    t_alu();
    t_extended();
    finish_test();
  end

  // The sequence needs about 110 cycles, so a hang is cut off well past that.
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    finish_test();
  end
endmodule
